//--- dv/mcd_dma_tb.sv
// self-checking bench for the multi-channel dma controller
`timescale 1ns/1ps
module mcd_dma_tb;
  localparam logic [31:0] TB = 32'h0000_1000;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic cpu_busy, busy_on, mem_ack;
  logic [31:0] haddr, hwdata, hrdata, dma_sreq, dma_breq, mem_rdata;
  logic [31:0] dma_done, rd, cw, bits;
  logic [1:0] htrans;
  logic [2:0] hsize, bc;
  logic [3:0] lat;
  mcd_pkg::mcd_mem_s mem_o;
  int n_mismatch, samples_checked, dst_wr, k, n0, i;
  assign hready = hreadyout;

  mcd_dma dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .dma_sreq(dma_sreq),
    .dma_breq(dma_breq), .cpu_busy(cpu_busy), .mem_o(mem_o),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .dma_done(dma_done));
  mcd_mem_model mem (.hclk(hclk), .hresetn(hresetn), .mem_o(mem_o),
    .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .dst_wr(dst_wr));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // processor steals two cycles in eight while enabled
  always @(posedge hclk) begin
    if (!hresetn) begin
      bc <= 3'h0;
      cpu_busy <= 1'b0;
    end else begin
      bc <= bc + 3'h1;
      cpu_busy <= busy_on && bc < 3'h2;
      if (cpu_busy) begin
        cmp({31'h0, mem_o.req}, 32'h0);
      end
    end
  end

  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 3000) begin
      n_mismatch++;
      test_done();
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    tmo(n);
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    cmp(rd, exp);
    cmp({31'h0, hresp}, 32'h0);
  endtask
  task automatic wait_req();
    int n;
    n = 0;
    while (mem_o.req !== 1'b1 && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    tmo(n);
  endtask
  task automatic wait_clr(input logic [7:0] a, input logic [31:0] m);
    int n;
    n = 0;
    rd = m;
    while ((rd & m) !== 32'h0 && n < 3000) begin
      ahb(1'b0, a, 32'h0);
      n++;
    end
    tmo(n);
  endtask
  task automatic wait_idle();
    wait_clr(mcd_pkg::R_STAT, 32'h1);
  endtask
  task automatic wait_done(input logic [31:0] b);
    int n;
    n = 0;
    while ((dma_done & b) !== b && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    tmo(n);
  endtask
  task automatic setcs(input int ch, input logic [31:0] s, d, c);
    mem.m[32'h400 + ch * 4] = s;
    mem.m[32'h401 + ch * 4] = d;
    mem.m[32'h402 + ch * 4] = c;
  endtask
  function automatic logic [31:0] cwf(input logic [1:0] md,
      input logic [9:0] n, input logic [3:0] arb, input logic [1:0] sz,
      input logic [1:0] si, input logic [1:0] di);
    return {8'h0, di, si, sz, 2'h0, arb, n - 10'h1, md};
  endfunction

  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    dma_sreq = 32'h0;
    dma_breq = 32'h0;
    busy_on = 1'b0;
    lat = 4'h0;
    n_mismatch = 0;
    samples_checked = 0;
    hresetn = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    for (k = 0; k < 10; k++) begin
      rdc((k == 9) ? 8'h3C : 8'(k * 4), 32'h0);
    end
    ahb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    rdc(8'h3C, 32'h0);
    ahb(1'b1, mcd_pkg::R_BASE, 32'hFFFF_FFFF);
    rdc(mcd_pkg::R_BASE, mcd_pkg::BASE_MASK);
    ahb(1'b1, mcd_pkg::R_BASE, TB);
    // software burst on the reserved channel, slow memory, busy cpu
    lat <= 4'h3;
    busy_on <= 1'b1;
    for (k = 0; k < 4; k++) begin
      mem.m[32'h800 + k] = 32'hA0 + k;
    end
    cw = cwf(mcd_pkg::MODE_BASIC, 10'd4, 4'h1, mcd_pkg::SZ_WORD, 2'h2, 2'h2);
    setcs(mcd_pkg::SW_CH, 32'h200C, 32'h300C, cw);
    bits = 32'h1 << mcd_pkg::SW_CH;
    ahb(1'b1, mcd_pkg::R_ENA, bits);
    ahb(1'b1, mcd_pkg::R_SWREQ, bits);
    wait_done(bits);
    wait_idle();
    for (k = 0; k < 4; k++) begin
      cmp(mem.m[32'hC00 + k], 32'hA0 + k);
    end
    cmp(mem.m[32'h402 + mcd_pkg::SW_CH * 4], cw & 32'hFFFF_F000);
    cmp(dma_done, bits);
    rdc(mcd_pkg::R_SWREQ, 32'h0);
    ahb(1'b1, mcd_pkg::R_DONE, bits);
    rdc(mcd_pkg::R_DONE, 32'h0);
    busy_on <= 1'b0;
    // single requests move one byte each to a fixed address
    lat <= 4'h0;
    mem.m[32'h840] = 32'h0033_2211;
    mem.m[32'hC40] = 32'h0;
    cw = cwf(mcd_pkg::MODE_BASIC, 10'd3, 4'h2, 2'h0, 2'h0,
             mcd_pkg::INC_NONE);
    setcs(9, 32'h2102, 32'h3100, cw);
    ahb(1'b1, mcd_pkg::R_ENA, 32'h0000_0200);
    for (k = 0; k < 3; k++) begin
      n0 = dst_wr;
      @(posedge hclk);
      dma_sreq <= 32'h0000_0200;
      wait_req();
      dma_sreq <= 32'h0;
      wait_idle();
      cmp(32'(dst_wr - n0), 32'h1);
      cmp(mem.m[32'hC40], 32'h11 * (k + 1));
    end
    cmp(dma_done, 32'h0000_0200);
    ahb(1'b1, mcd_pkg::R_DONE, 32'h0000_0200);
    // masked line, then single line with burst-only set: no service
    setcs(9, 32'h2102, 32'h3100, cw);
    ahb(1'b1, mcd_pkg::R_ENA, 32'h0000_0200);
    for (k = 0; k < 2; k++) begin
      ahb(1'b1, k ? mcd_pkg::R_UBURST : mcd_pkg::R_MASK, 32'h0000_0200);
      @(posedge hclk);
      dma_sreq <= 32'h0000_0200;
      n0 = 0;
      for (i = 0; i < 40; i++) begin
        @(posedge hclk);
        n0 += int'(mem_o.req === 1'b1);
      end
      cmp(32'(n0), 32'h0);
      dma_sreq <= 32'h0;
      ahb(1'b1, k ? mcd_pkg::R_UBURST : mcd_pkg::R_MASK, 32'h0);
    end
    // two software requests at once: high level first, else lower number
    cw = cwf(mcd_pkg::MODE_BASIC, 10'd1, 4'h0, mcd_pkg::SZ_WORD, 2'h2, 2'h2);
    bits = 32'h0010_0001;
    for (k = 0; k < 2; k++) begin
      ahb(1'b1, mcd_pkg::R_PRIO, k ? 32'h0 : 32'h0010_0000);
      rdc(mcd_pkg::R_PRIO, k ? 32'h0 : 32'h0010_0000);
      setcs(0, 32'h2000, 32'h3200, cw);
      setcs(20, 32'h2004, 32'h3204, cw);
      ahb(1'b1, mcd_pkg::R_ENA, bits);
      ahb(1'b1, mcd_pkg::R_SWREQ, bits);
      wait_req();
      cmp(mem_o.addr, TB + (k ? 32'h0 : 32'h140));
      wait_done(bits);
      cmp(dma_done, bits);
      ahb(1'b1, mcd_pkg::R_DONE, bits);
    end
    // ping-pong on channel 3: primary buffer, alternate buffer, then stop
    cw = cwf(mcd_pkg::MODE_PING, 10'd1, 4'h0, mcd_pkg::SZ_WORD, 2'h2, 2'h2);
    mem.m[32'h880] = 32'hC0;
    mem.m[32'h881] = 32'hC1;
    setcs(3, 32'h2200, 32'h3300, cw);
    setcs(35, 32'h2204, 32'h3304, cw);
    bits = 32'h0000_0008;
    ahb(1'b1, mcd_pkg::R_ENA, bits);
    ahb(1'b1, mcd_pkg::R_SWREQ, bits);
    wait_clr(mcd_pkg::R_ENA, bits);
    wait_idle();
    cmp(mem.m[32'hCC0], 32'hC0);
    cmp(mem.m[32'hCC1], 32'hC1);
    cmp(mem.m[32'h40E], cw & 32'hFFFF_F000);
    cmp(dma_done, bits);
    rdc(mcd_pkg::R_ALT, 32'h0);
    ahb(1'b1, mcd_pkg::R_DONE, bits);
    // scatter-gather on channel 6: two one-word tasks from one request
    cw = cwf(mcd_pkg::MODE_BASIC, 10'd1, 4'h0, mcd_pkg::SZ_WORD, 2'h2, 2'h2);
    for (k = 0; k < 2; k++) begin
      mem.m[32'h900 + k * 4] = 32'h2500 + k * 4;
      mem.m[32'h901 + k * 4] = 32'h3500 + k * 4;
      mem.m[32'h902 + k * 4] = cw;
      mem.m[32'h903 + k * 4] = 32'h0;
      mem.m[32'h940 + k] = 32'hB0 + k;
    end
    setcs(6, 32'h241C, 32'h126C, cwf(mcd_pkg::MODE_SG, 10'd8, 4'h2,
          mcd_pkg::SZ_WORD, 2'h2, 2'h2));
    bits = 32'h0000_0040;
    ahb(1'b1, mcd_pkg::R_ENA, bits);
    ahb(1'b1, mcd_pkg::R_SWREQ, bits);
    wait_done(bits);
    wait_idle();
    cmp(mem.m[32'hD40], 32'hB0);
    cmp(mem.m[32'hD41], 32'hB1);
    rdc(mcd_pkg::R_ALT, 32'h0);
    cmp(dma_done, bits);
    test_done();
  end
endmodule

//--- dv/mcd_mem_model.sv
// system memory and bus partner model for the dma controller
`timescale 1ns/1ps
module mcd_mem_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire mcd_pkg::mcd_mem_s mem_o,
  input wire logic [3:0] lat,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  output int dst_wr
);
  logic [31:0] m [0:4095];
  logic [3:0] cnt;
  logic [31:0] junk;
  logic [11:0] idx;
  logic [4:0] sh;
  assign idx = mem_o.addr[13:2];
  assign sh = {mem_o.addr[1:0], 3'h0};
  // released data lines carry a moving pattern, never the last value
  assign mem_rdata = mem_ack ? m[idx] >> sh : junk;
  // plain always: the bench preloads the array by hierarchy
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      junk <= 32'h5A5A_A5A5;
      dst_wr <= 0;
    end else begin
      junk <= {junk[30:0], ~junk[31]};
      mem_ack <= mem_o.req && !mem_ack && cnt >= lat;
      cnt <= (mem_o.req && !mem_ack) ? cnt + 4'h1 : 4'h0;
      if (mem_o.req && mem_ack && mem_o.we) begin
        // control structures and data both live here
        if (mem_o.addr[15:12] == 4'h3) begin
          dst_wr <= dst_wr + 1;
        end
        case (mem_o.size)
          2'h0: m[idx][sh +: 8] <= mem_o.wdata[7:0];
          2'h1: m[idx][sh +: 16] <= mem_o.wdata[15:0];
          default: m[idx] <= mem_o.wdata;
        endcase
      end
    end
  end
endmodule

//--- rtl/mcd_dma.sv
// dma engine, its data fifo and its checks
`timescale 1ns/1ps
module mcd_fifo #(
  parameter int W = 32,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } mcd_fptr_s;
  mcd_fptr_s f_q, f_d;
  logic [W-1:0] mem [D];
  logic full, empty;
  assign empty = f_q.wp == f_q.rp;
  assign full = (f_q.wp[AW] != f_q.rp[AW]) &&
                (f_q.wp[AW-1:0] == f_q.rp[AW-1:0]);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[f_q.rp[AW-1:0]];
  always_comb begin
    f_d = f_q;
    if (in_valid && !full) begin
      f_d.wp = f_q.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      f_d.rp = f_q.rp + 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end
  // storage needs no reset; pointers guard it
  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem[f_q.wp[AW-1:0]] <= in_data;
    end
  end
endmodule

module mcd_dma (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [31:0] dma_sreq,
  input wire logic [31:0] dma_breq,
  input wire logic cpu_busy,
  output mcd_pkg::mcd_mem_s mem_o,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic [31:0] dma_done
);
  mcd_pkg::mcd_st_s s, n;
  logic [31:0] pend, bvec, clr, dset, swset, swclr;
  logic [5:0] pk;
  logic ack, fpush, fpop, f_ir, f_ov, sgp;
  logic [31:0] f_od;
  logic [10:0] rem, remn, arb, lft, wlft;
  logic [31:0] ncw;

  function automatic logic [5:0] pick(input logic [31:0] v,
                                      input logic [31:0] p);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i] && !p[i]) r = {1'b1, 5'(i)};
    end
    for (int i = 31; i >= 0; i--) begin
      if (v[i] && p[i]) r = {1'b1, 5'(i)};
    end
    return r;
  endfunction

  // end pointers are inclusive, so count back from the end
  function automatic logic [31:0] item_addr(input logic [31:0] e,
                                            input logic [10:0] left,
                                            input logic [1:0] inc);
    logic [31:0] k;
    k = {21'h0, left - 11'h1};
    return (inc == mcd_pkg::INC_NONE) ? e : e - (k << inc);
  endfunction

  function automatic logic [31:0] sbase(input logic [31:0] b,
                                        input logic [4:0] c,
                                        input logic a);
    return b + (a ? mcd_pkg::ALT_OFS : 32'h0) + {23'h0, c, 4'h0};
  endfunction

  mcd_fifo #(.W(mcd_pkg::FIFO_W), .D(mcd_pkg::FIFO_D)) u_fifo (
    .clk(hclk),
    .rst_n(hresetn),
    .in_valid(fpush),
    .in_ready(f_ir),
    .in_data(mem_rdata),
    .out_valid(f_ov),
    .out_ready(fpop),
    .out_data(f_od)
  );

  // peripheral lines only on bound channels, never on 30
  assign bvec = (dma_breq & mcd_pkg::PERIPH_CH & ~s.mask) | s.swp;
  assign pend = (((dma_sreq & ~s.ub) | dma_breq) & mcd_pkg::PERIPH_CH
                & ~s.mask | s.swp) & s.en;
  assign pk = pick(pend, s.prio);
  // core has the bus: the request is withdrawn while it is busy
  assign mem_o.req = s.mreq & ~cpu_busy;
  assign mem_o.we = s.mwe;
  assign mem_o.size = s.msz;
  assign mem_o.addr = s.maddr;
  assign mem_o.wdata = s.mwdata;
  assign ack = mem_o.req & mem_ack;
  assign hreadyout = ~s.rdw;
  assign hrdata = s.rdata;
  assign hresp = 1'b0;
  assign dma_done = s.done;
  assign rem = {1'b0, s.cw[mcd_pkg::CW_N +: 10]} + 11'h1;
  assign remn = {1'b0, mem_rdata[mcd_pkg::CW_N +: 10]} + 11'h1;
  assign arb = 11'h1 << ((mem_rdata[mcd_pkg::CW_ARB +: 4] > mcd_pkg::ARB_MAX)
               ? mcd_pkg::ARB_MAX : mem_rdata[mcd_pkg::CW_ARB +: 4]);
  assign lft = rem - s.burst;
  // a task list lands in the alternate structure four words per burst,
  // so the copying channel must use an arbitration size of four
  assign sgp = s.cw[mcd_pkg::CW_MODE +: 2] == mcd_pkg::MODE_SG &&
               !s.alt[s.ch];
  assign wlft = sgp ? {9'h0, 2'(rem - s.wcnt - 11'h1)} + 11'h1
                    : rem - s.wcnt;

  always_comb begin
    ncw = s.cw;
    if (lft == 11'h0) begin
      ncw[mcd_pkg::CW_MODE +: 2] = mcd_pkg::MODE_STOP;
      ncw[mcd_pkg::CW_N +: 10] = 10'h0;
    end else begin
      ncw[mcd_pkg::CW_N +: 10] = 10'(lft - 11'h1);
    end
  end

  always_comb begin
    n = s;
    fpush = 1'b0;
    fpop = 1'b0;
    clr = 32'h0;
    dset = 32'h0;
    swset = 32'h0;
    swclr = 32'h0;
    n.aph = hsel & hready & htrans[1] & hwrite;
    n.rdw = hsel & hready & htrans[1] & ~hwrite;
    if (hsel && hready && htrans[1]) begin
      n.aadr = {haddr[7:2], 2'h0};
    end
    case (s.st)
      mcd_pkg::ST_IDLE: begin
        if (pk[5]) begin
          n.ch = pk[4:0];
          n.fidx = 2'h0;
          n.st = mcd_pkg::ST_FETCH;
          n.mreq = 1'b1;
          n.mwe = 1'b0;
          n.msz = mcd_pkg::SZ_WORD;
          n.maddr = sbase(s.base, pk[4:0], s.alt[pk[4:0]]);
        end
      end
      mcd_pkg::ST_FETCH: begin
        if (ack) begin
          n.fidx = s.fidx + 2'h1;
          n.maddr = s.maddr + mcd_pkg::WORD_STEP;
          case (s.fidx)
            2'h0: n.src = mem_rdata;
            2'h1: n.dst = mem_rdata;
            default: n.cw = mem_rdata;
          endcase
          if (s.fidx == mcd_pkg::LAST_WORD) begin
            n.mreq = 1'b0;
            n.rcnt = 11'h0;
            n.wcnt = 11'h0;
            n.bq = bvec[s.ch];
            if (mem_rdata[mcd_pkg::CW_MODE +: 2] == mcd_pkg::MODE_STOP) begin
              n.en[s.ch] = 1'b0;
              n.st = mcd_pkg::ST_IDLE;
            end else begin
              n.st = mcd_pkg::ST_XFER;
              n.burst = !bvec[s.ch] ? 11'h1 :
                        (arb < remn ? arb : remn);
            end
          end
        end
      end
      mcd_pkg::ST_XFER: begin
        if (s.mreq) begin
          if (ack) begin
            n.mreq = 1'b0;
            if (s.mwe) begin
              n.wcnt = s.wcnt + 11'h1;
            end else begin
              fpush = 1'b1;
              n.rcnt = s.rcnt + 11'h1;
            end
          end
        end else if (f_ov && (s.rcnt == s.burst || !f_ir)) begin
          fpop = 1'b1;
          n.mreq = 1'b1;
          n.mwe = 1'b1;
          n.msz = s.cw[mcd_pkg::CW_SZ +: 2];
          n.mwdata = f_od;
          n.maddr = item_addr(s.dst, wlft,
                              s.cw[mcd_pkg::CW_DI +: 2]);
        end else if (s.rcnt != s.burst) begin
          n.mreq = 1'b1;
          n.mwe = 1'b0;
          n.msz = s.cw[mcd_pkg::CW_SZ +: 2];
          n.maddr = item_addr(s.src, rem - s.rcnt,
                              s.cw[mcd_pkg::CW_SI +: 2]);
        end else begin
          n.st = mcd_pkg::ST_WB;
          n.mreq = 1'b1;
          n.mwe = 1'b1;
          n.msz = mcd_pkg::SZ_WORD;
          n.mwdata = ncw;
          n.maddr = sbase(s.base, s.ch, s.alt[s.ch]) + mcd_pkg::CW_OFS;
        end
      end
      mcd_pkg::ST_WB: begin
        if (ack) begin
          n.mreq = 1'b0;
          n.st = mcd_pkg::ST_IDLE;
          if (s.cw[mcd_pkg::CW_MODE +: 2] == mcd_pkg::MODE_SG &&
              !s.alt[s.ch]) begin
            n.alt[s.ch] = 1'b1;
            n.sgm[s.ch] = 1'b1;
            n.sgl[s.ch] = lft == 11'h0;
          end else if (lft == 11'h0) begin
            if (s.cw[mcd_pkg::CW_MODE +: 2] == mcd_pkg::MODE_PING) begin
              dset[s.ch] = 1'b1;
              n.alt[s.ch] = ~s.alt[s.ch];
            end else if (s.sgm[s.ch] && s.alt[s.ch]) begin
              n.alt[s.ch] = 1'b0;
              if (s.sgl[s.ch]) begin
                dset[s.ch] = 1'b1;
                swclr[s.ch] = 1'b1;
                n.sgm[s.ch] = 1'b0;
              end
            end else begin
              dset[s.ch] = 1'b1;
              swclr[s.ch] = 1'b1;
            end
          end
        end
      end
      default: n.st = mcd_pkg::ST_IDLE;
    endcase
    // software writes follow the engine, so they win over hw updates, except a done clear, which loses to a done set in the same cycle
    if (s.aph) begin
      case (s.aadr)
        mcd_pkg::R_BASE: n.base = hwdata & mcd_pkg::BASE_MASK;
        mcd_pkg::R_SWREQ: swset = hwdata;
        mcd_pkg::R_UBURST: n.ub = hwdata;
        mcd_pkg::R_MASK: n.mask = hwdata;
        mcd_pkg::R_ENA: n.en = hwdata;
        mcd_pkg::R_PRIO: n.prio = hwdata;
        mcd_pkg::R_ALT: n.alt = hwdata;
        mcd_pkg::R_DONE: clr = hwdata;
        default: ;
      endcase
    end
    n.swp = (s.swp & ~swclr) | swset;
    n.done = (s.done & ~clr) | dset;
    if (s.rdw) begin
      case (s.aadr)
        mcd_pkg::R_STAT: n.rdata = {23'h0, s.ch, 3'h0,
                                    s.st != mcd_pkg::ST_IDLE};
        mcd_pkg::R_BASE: n.rdata = s.base;
        mcd_pkg::R_SWREQ: n.rdata = s.swp;
        mcd_pkg::R_UBURST: n.rdata = s.ub;
        mcd_pkg::R_MASK: n.rdata = s.mask;
        mcd_pkg::R_ENA: n.rdata = s.en;
        mcd_pkg::R_PRIO: n.rdata = s.prio;
        mcd_pkg::R_ALT: n.rdata = s.alt;
        mcd_pkg::R_DONE: n.rdata = s.done;
        default: n.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_cpu_yield: assert property (cpu_busy |-> !mem_o.req)
    else $error("dma request while cpu busy");
  chk_mem_hold: assert property (s.mreq && !ack |=>
    s.mreq && $stable(s.maddr) && $stable(s.mwe))
    else $error("memory request dropped before ack");
  chk_done_sticky: assert property (
    ((s.done & ~clr) != 32'h0) |=> ((s.done & $past(s.done & ~clr)) ==
    $past(s.done & ~clr)))
    else $error("done flag lost without clear");
  chk_burst_cap: assert property (s.st == mcd_pkg::ST_XFER |->
    s.burst <= rem && s.burst != 11'h0 && s.wcnt <= s.burst)
    else $error("burst exceeds items left");
  chk_single_one: assert property (s.st == mcd_pkg::ST_XFER && !s.bq |->
    s.burst == 11'h1)
    else $error("single request moved more than one item");
  chk_sw_only: assert property (pend[mcd_pkg::SW_CH] |->
    s.swp[mcd_pkg::SW_CH])
    else $error("hardware request on software channel");
  chk_prio_high: assert property (s.st == mcd_pkg::ST_IDLE &&
    (pend & s.prio) != 32'h0 |=> s.prio[s.ch])
    else $error("default channel beat high priority");
  chk_chan_zero: assert property (s.st == mcd_pkg::ST_IDLE && pend[0] &&
    (s.prio[0] || s.prio == 32'h0) |=> s.ch == 5'h0)
    else $error("channel zero not first");
  chk_rearb: assert property (s.st == mcd_pkg::ST_WB && ack |=>
    s.st == mcd_pkg::ST_IDLE ##1 s.st != mcd_pkg::ST_XFER)
    else $error("no rearbitration after burst");
  chk_done_set: assert property (dset != 32'h0 |=>
    (s.done & $past(dset)) == $past(dset))
    else $error("completion not flagged");

  cov_ping: cover property (s.st == mcd_pkg::ST_WB && ack &&
    s.cw[mcd_pkg::CW_MODE +: 2] == mcd_pkg::MODE_PING && lft == 11'h0);
  cov_sg_alt: cover property (s.st == mcd_pkg::ST_WB && ack && s.sgm[s.ch]
    && s.alt[s.ch] && s.sgl[s.ch]);
  cov_burst: cover property (s.st == mcd_pkg::ST_XFER && s.burst > 11'h1 &&
    s.wcnt == s.burst);
  cov_stall: cover property (s.mreq && cpu_busy ##1 ack);
endmodule

//--- rtl/mcd_pkg.sv
// constants, states and carriers of the multi-channel dma controller
package mcd_pkg;
  localparam int NCH = 32;
  localparam int FIFO_W = 32;
  localparam int FIFO_D = 16;
  localparam int SW_CH = 30;
  // channels bound to peripherals: two serial ports, rx and tx apart
  localparam logic [31:0] PERIPH_CH = 32'h0000_0F00;
  // register byte offsets
  localparam logic [7:0] R_STAT = 8'h00;
  localparam logic [7:0] R_BASE = 8'h04;
  localparam logic [7:0] R_SWREQ = 8'h08;
  localparam logic [7:0] R_UBURST = 8'h0C;
  localparam logic [7:0] R_MASK = 8'h10;
  localparam logic [7:0] R_ENA = 8'h14;
  localparam logic [7:0] R_PRIO = 8'h18;
  localparam logic [7:0] R_ALT = 8'h1C;
  localparam logic [7:0] R_DONE = 8'h20;
  localparam logic [31:0] BASE_MASK = 32'hFFFF_FC00;
  // control structure layout
  localparam logic [31:0] ALT_OFS = 32'h0000_0200;
  localparam logic [31:0] CW_OFS = 32'h0000_0008;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [1:0] LAST_WORD = 2'h2;
  // control word fields
  localparam int CW_MODE = 0;
  localparam int CW_N = 2;
  localparam int CW_ARB = 12;
  localparam int CW_SZ = 18;
  localparam int CW_SI = 20;
  localparam int CW_DI = 22;
  localparam logic [3:0] ARB_MAX = 4'hA;
  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_BASIC = 2'h1;
  localparam logic [1:0] MODE_PING = 2'h2;
  localparam logic [1:0] MODE_SG = 2'h3;
  localparam logic [1:0] INC_NONE = 2'h3;
  localparam logic [1:0] SZ_WORD = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_XFER, ST_WB} mcd_state_e;

  typedef struct packed {
    logic req;
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mcd_mem_s;

  typedef struct packed {
    logic [31:0] base, en, mask, prio, ub, alt, swp, done, sgm, sgl;
    mcd_state_e st;
    logic [4:0] ch;
    logic [31:0] src, dst, cw;
    logic [10:0] burst, rcnt, wcnt;
    logic [1:0] fidx;
    logic bq;
    logic mreq, mwe;
    logic [1:0] msz;
    logic [31:0] maddr, mwdata;
    logic aph, rdw;
    logic [7:0] aadr;
    logic [31:0] rdata;
  } mcd_st_s;
endpackage
